// ---- rtl/drive_output_function_select.sv ----
// function selector for standard outputs and relay, with contactor sequencing
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - code 13: output on while drive halted, any halt source
// - code 14: output on when a reference value is at its limit
// - code 15: output on while torque exceeds torque threshold
// - code 16: output on while speed exceeds speed threshold
// - codes 17,18,19: position, speed, torque limitation active
// - code 21: output drives the motor contactor via sequencing
// - code 39: output follows bus value, refreshed every 1 ms
// - code 40: output follows bus value, refreshed on nc cycle
// - code 23 any warning; 24..33 one specific warning each
// - all warnings compare against one warning level setting
// - code 34: table positioning automatic and activated
// - code 55: safe torque off active
// - code 56: chopper fault caught on falling edge of chopper status
// - contactor closes before the power stage is enabled
// - contactor stays closed until power stage off, then opens
// - relay selector on contactor function needs no outside sequencing
// - programmable delay covers contactor close and open times while the relay selector is on the contactor function
// - reference applied only after start, and after elapsed delay while the relay selector is on the contactor function
// - standard outputs active low
module drive_output_function_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire drive_output_pkg::drive_meas_t meas,
  input wire drive_output_pkg::drive_status_t status,
  input wire logic start_enable,
  output logic [2:0] standard_output_n,
  output logic relay_out,
  output logic contactor_drive,
  output logic power_stage_enable,
  output logic reference_apply
);
  localparam int unsigned NW = drive_output_pkg::NUM_WARN;
  localparam int unsigned NO = drive_output_pkg::NUM_STD_OUTPUTS;
  logic [17:0] out_sel_ff;
  logic [5:0] relay_function_select_ff;
  logic [15:0] contactor_delay_time_ff;
  logic [15:0] torque_threshold_value_ff;
  logic [15:0] speed_threshold_value_ff;
  logic [15:0] warning_level_setting_ff;
  logic [3:0] bus_value_ff;
  logic [3:0] bus_fast_ff;
  logic [3:0] bus_nc_ff;
  logic start_ff;
  logic chopper_fault_ff;
  logic chopper_prev_ff;
  logic [16:0] ms_cnt_ff;
  logic [15:0] delay_ms_ff;
  drive_output_pkg::contactor_state_t ct_state_ff;
  drive_output_pkg::contactor_state_t nxt_ct_state;
  logic [NO-1:0] std_ff;
  logic relay_ff;
  logic contactor_ff;
  logic stage_ff;
  logic ref_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  // apb decode
  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic hit_out = paddr == drive_output_pkg::ADDR_OUT_SEL;
  wire logic hit_relay = paddr == drive_output_pkg::ADDR_RELAY_SEL;
  wire logic hit_delay = paddr == drive_output_pkg::ADDR_DELAY;
  wire logic hit_tq = paddr == drive_output_pkg::ADDR_TORQUE_TH;
  wire logic hit_sp = paddr == drive_output_pkg::ADDR_SPEED_TH;
  wire logic hit_wl = paddr == drive_output_pkg::ADDR_WARN_LVL;
  wire logic hit_bus = paddr == drive_output_pkg::ADDR_BUS_OUT;
  wire logic hit_ctrl = paddr == drive_output_pkg::ADDR_CTRL;
  wire logic hit_stat = paddr == drive_output_pkg::ADDR_STATUS;
  wire logic mapped = hit_out | hit_relay | hit_delay | hit_tq | hit_sp | hit_wl | hit_bus
    | hit_ctrl | hit_stat;
  wire logic ctrl_wr = wr && hit_ctrl && pstrb[0];
  wire logic fault_clr = ctrl_wr && pwdata[drive_output_pkg::CTRL_SHUTDOWN_CLR];
  // warning comparisons, all against the single level setting
  wire logic [NW-1:0] warn_vec = {
    meas.torque >= warning_level_setting_ff,
    meas.motor_i2t >= warning_level_setting_ff,
    meas.speed >= warning_level_setting_ff,
    meas.current >= warning_level_setting_ff,
    meas.internal_temp >= warning_level_setting_ff,
    meas.heatsink_temp >= warning_level_setting_ff,
    meas.motor_temp >= warning_level_setting_ff,
    meas.stage_i2t >= warning_level_setting_ff,
    meas.dc_voltage >= warning_level_setting_ff,
    meas.dc_voltage <= ~warning_level_setting_ff
  };
  wire logic torque_above_threshold = meas.torque > torque_threshold_value_ff;
  wire logic speed_above_threshold = meas.speed > speed_threshold_value_ff;
  wire logic table_positioning_active = status.table_auto && status.table_on;
  wire logic chopper_fall = chopper_prev_ff && !status.chopper_ok;
  // map a selector code to an active-high function level
  function automatic logic pick(input logic [5:0] code, input logic ct);
    logic r;
    r = 1'b0;
    case (code)
      drive_output_pkg::FS_HALT: r = status.halt;
      drive_output_pkg::FS_LIMIT: r = status.ref_at_limit;
      drive_output_pkg::FS_TORQUE_GT: r = torque_above_threshold;
      drive_output_pkg::FS_SPEED_GT: r = speed_above_threshold;
      drive_output_pkg::FS_POS_LIM: r = status.position_ref_limited;
      drive_output_pkg::FS_SPEED_LIM: r = status.speed_ref_limited;
      drive_output_pkg::FS_TORQUE_LIM: r = status.torque_limited;
      drive_output_pkg::FS_CONTACTOR: r = ct;
      drive_output_pkg::FS_PLC: r = status.plc_out;
      drive_output_pkg::FS_WARN_ANY: r = |warn_vec;
      drive_output_pkg::FS_TABLE_ACT: r = table_positioning_active;
      drive_output_pkg::FS_BUS_FAST: r = bus_fast_ff[0];
      drive_output_pkg::FS_BUS_NC: r = bus_nc_ff[0];
      drive_output_pkg::FS_STO: r = status.safe_torque_off_active;
      drive_output_pkg::FS_CHOPPER: r = chopper_fault_ff;
      drive_output_pkg::FS_SYNC: r = status.sync_motion_engaged;
      default: begin
        if (code >= drive_output_pkg::FS_WARN_FIRST && code <= drive_output_pkg::FS_WARN_LAST) begin
          r = warn_vec[4'(code - drive_output_pkg::FS_WARN_FIRST)];
        end else if (code >= drive_output_pkg::FS_TAB_FIRST
                     && code <= drive_output_pkg::FS_TAB_LAST) begin
          r = status.table_index[2'(code - drive_output_pkg::FS_TAB_FIRST)];
        end else begin
          r = 1'b0;
        end
      end
    endcase
    return r;
  endfunction
  // contactor sequencing
  wire logic ct_enabled = relay_function_select_ff == drive_output_pkg::FS_CONTACTOR;
  wire logic run_req = start_ff && start_enable;
  wire logic ms_tick = ms_cnt_ff == 17'(drive_output_pkg::MS_CYCLES - 1);
  wire logic delay_done = delay_ms_ff >= contactor_delay_time_ff;
  always_comb begin
    nxt_ct_state = ct_state_ff;
    case (ct_state_ff)
      drive_output_pkg::CT_OPEN: begin
        if (run_req) begin
          nxt_ct_state = drive_output_pkg::CT_CLOSING;
        end
      end
      drive_output_pkg::CT_CLOSING: begin
        if (!run_req) begin
          nxt_ct_state = drive_output_pkg::CT_OPENING;
        end else if (delay_done || !ct_enabled) begin
          nxt_ct_state = drive_output_pkg::CT_RUN;
        end
      end
      drive_output_pkg::CT_RUN: begin
        if (!run_req) begin
          nxt_ct_state = drive_output_pkg::CT_STAGE_OFF;
        end
      end
      drive_output_pkg::CT_STAGE_OFF: begin
        nxt_ct_state = drive_output_pkg::CT_OPENING;
      end
      drive_output_pkg::CT_OPENING: begin
        if (delay_done || !ct_enabled) begin
          nxt_ct_state = drive_output_pkg::CT_OPEN;
        end
      end
      default: nxt_ct_state = drive_output_pkg::CT_OPEN;
    endcase
  end
  wire logic nxt_contactor = nxt_ct_state != drive_output_pkg::CT_OPEN;
  wire logic nxt_stage = nxt_ct_state == drive_output_pkg::CT_RUN;
  wire logic ct_moving = ct_state_ff == drive_output_pkg::CT_CLOSING
    || ct_state_ff == drive_output_pkg::CT_OPENING;
  wire logic [31:0] rd_mux = hit_out ? {14'h0000, out_sel_ff}
    : hit_relay ? {26'h0000000, relay_function_select_ff}
    : hit_delay ? {16'h0000, contactor_delay_time_ff}
    : hit_tq ? {16'h0000, torque_threshold_value_ff}
    : hit_sp ? {16'h0000, speed_threshold_value_ff}
    : hit_wl ? {16'h0000, warning_level_setting_ff}
    : hit_bus ? {28'h0000000, bus_value_ff}
    : hit_ctrl ? {31'h00000000, start_ff}
    : hit_stat ? {19'h00000, warn_vec, ct_state_ff}
    : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sel_ff <= 18'h00000;
      relay_function_select_ff <= 6'h00;
      contactor_delay_time_ff <= drive_output_pkg::DELAY_RESET_MS;
      torque_threshold_value_ff <= 16'hffff;
      speed_threshold_value_ff <= 16'hffff;
      warning_level_setting_ff <= 16'hffff;
      bus_value_ff <= 4'h0;
      start_ff <= 1'b0;
    end else if (wr && mapped) begin
      if (hit_out) begin
        out_sel_ff <= pwdata[17:0];
      end
      if (hit_relay) begin
        relay_function_select_ff <= pwdata[5:0];
      end
      if (hit_delay) begin
        contactor_delay_time_ff <= pwdata[15:0];
      end
      if (hit_tq) begin
        torque_threshold_value_ff <= pwdata[15:0];
      end
      if (hit_sp) begin
        speed_threshold_value_ff <= pwdata[15:0];
      end
      if (hit_wl) begin
        warning_level_setting_ff <= pwdata[15:0];
      end
      if (hit_bus) begin
        bus_value_ff <= pwdata[3:0];
      end
      if (ctrl_wr) begin
        start_ff <= pwdata[drive_output_pkg::CTRL_START];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff <= 17'h00000;
      bus_fast_ff <= 4'h0;
      bus_nc_ff <= 4'h0;
    end else begin
      ms_cnt_ff <= ms_tick ? 17'h00000 : ms_cnt_ff + 17'h00001;
      if (ms_tick) begin
        bus_fast_ff <= bus_value_ff;
      end
      if (status.nc_cycle) begin
        bus_nc_ff <= bus_value_ff;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chopper_prev_ff <= 1'b1;
      chopper_fault_ff <= 1'b0;
    end else begin
      chopper_prev_ff <= status.chopper_ok;
      // a new fault edge wins over a clear in the same cycle
      chopper_fault_ff <= chopper_fall | (chopper_fault_ff & ~fault_clr);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ct_state_ff <= drive_output_pkg::CT_OPEN;
      delay_ms_ff <= 16'h0000;
    end else begin
      ct_state_ff <= nxt_ct_state;
      if (nxt_ct_state != ct_state_ff || !ct_moving) begin
        delay_ms_ff <= 16'h0000;
      end else if (ms_tick && !delay_done) begin
        delay_ms_ff <= delay_ms_ff + 16'h0001;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contactor_ff <= 1'b0;
      stage_ff <= 1'b0;
      ref_ff <= 1'b0;
      relay_ff <= 1'b0;
    end else begin
      contactor_ff <= nxt_contactor;
      stage_ff <= nxt_stage;
      ref_ff <= nxt_stage && run_req;
      relay_ff <= pick(relay_function_select_ff, nxt_contactor);
    end
  end
  genvar gi;
  for (gi = 0; gi < NO; gi++) begin : g_std
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        std_ff[gi] <= 1'b1;
      end else begin
        std_ff[gi] <= ~pick(out_sel_ff[gi*6 +: 6], nxt_contactor);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= rd_mux;
      pslverr_ff <= !mapped;
    end
  end
  // no wait state: read data captured in setup, presented in access
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign standard_output_n = std_ff;
  assign relay_out = relay_ff;
  assign contactor_drive = contactor_ff;
  assign power_stage_enable = stage_ff;
  assign reference_apply = ref_ff;
  a_stage_needs_contactor: assert property (@(posedge pclk) disable iff (!presetn)
    power_stage_enable |-> contactor_drive) else $error("stage on with contactor open");
  a_open_after_stage: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(contactor_drive) |-> !power_stage_enable && !$past(power_stage_enable))
    else $error("contactor opened with stage on");
  a_ref_needs_stage: assert property (@(posedge pclk) disable iff (!presetn)
    reference_apply |-> power_stage_enable && contactor_drive && $past(run_req))
    else $error("ref without stage");
  a_close_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(power_stage_enable) && ct_enabled |-> delay_done || $past(delay_done))
    else $error("stage on before delay");
  a_chop_edge: assert property (@(posedge pclk) disable iff (!presetn)
    chopper_fall |=> chopper_fault_ff) else $error("chopper edge lost");
  a_halt_out: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[5:0] == drive_output_pkg::FS_HALT && $stable(out_sel_ff) && status.halt
    |=> !standard_output_n[0]) else $error("halt not low");
  a_undef_off: assert property (@(posedge pclk) disable iff (!presetn)
    $past(out_sel_ff[5:0]) == 6'h14 |-> standard_output_n[0]) else $error("undef active");
  a_torque_out: assert property (@(posedge pclk) disable iff (!presetn)
    relay_function_select_ff == drive_output_pkg::FS_TORQUE_GT && $stable(relay_function_select_ff)
    |=> relay_out == $past(torque_above_threshold)) else $error("torque relay");
  a_fast_bus: assert property (@(posedge pclk) disable iff (!presetn)
    !ms_tick |=> $stable(bus_fast_ff)) else $error("bus out off tick");
  a_limit_out: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[5:0] == drive_output_pkg::FS_LIMIT
    |=> standard_output_n[0] == !$past(status.ref_at_limit))
    else $error("limit out");
  a_speed_out: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[11:6] == drive_output_pkg::FS_SPEED_GT
    |=> standard_output_n[1] == !$past(speed_above_threshold))
    else $error("speed out");
  a_poslim_out: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[5:0] == drive_output_pkg::FS_POS_LIM
    |=> standard_output_n[0] == !$past(status.position_ref_limited))
    else $error("position limit out");
  a_warn_any: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[11:6] == drive_output_pkg::FS_WARN_ANY
    |=> standard_output_n[1] == !$past(|warn_vec))
    else $error("warning out");
  a_table_act: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[5:0] == drive_output_pkg::FS_TABLE_ACT
    |=> standard_output_n[0] == !$past(table_positioning_active))
    else $error("table active out");
  a_sto_out: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[5:0] == drive_output_pkg::FS_STO
    |=> standard_output_n[0] == !$past(status.safe_torque_off_active))
    else $error("sto out");
  a_tab_bit: assert property (@(posedge pclk) disable iff (!presetn)
    out_sel_ff[5:0] == drive_output_pkg::FS_TAB_FIRST
    |=> standard_output_n[0] == !$past(status.table_index[0]))
    else $error("table bit out");
  a_relay_contactor: assert property (@(posedge pclk) disable iff (!presetn)
    ct_enabled |=> relay_out == contactor_drive)
    else $error("relay not contactor");
  a_nc_latch: assert property (@(posedge pclk) disable iff (!presetn)
    status.nc_cycle |=> bus_nc_ff == $past(bus_value_ff))
    else $error("nc latch missed");
  a_nc_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !status.nc_cycle |=> $stable(bus_nc_ff))
    else $error("nc out off cycle");
  a_close_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(contactor_drive) |-> !power_stage_enable)
    else $error("stage on at close");
  a_stage_off_first: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(power_stage_enable) |-> contactor_drive)
    else $error("contactor open at stage off");
  c_run: cover property (@(posedge pclk) disable iff (!presetn) $rose(reference_apply));
  c_shutdown: cover property (@(posedge pclk) disable iff (!presetn) $fell(contactor_drive));
  c_chop: cover property (@(posedge pclk) disable iff (!presetn) $rose(chopper_fault_ff));
  c_relay_ct: cover property (@(posedge pclk) disable iff (!presetn)
    ct_enabled && $rose(contactor_drive));
  c_nc_out: cover property (@(posedge pclk) disable iff (!presetn) $rose(bus_nc_ff[0]));
endmodule
`default_nettype wire

// ---- rtl/drive_output_pkg.sv ----
// shared constants and types for the drive output function selector
package drive_output_pkg;
  localparam int unsigned NUM_STD_OUTPUTS = 3;
  localparam int unsigned SEL_W = 6;
  localparam logic [5:0] FS_HALT = 6'h0d;
  localparam logic [5:0] FS_LIMIT = 6'h0e;
  localparam logic [5:0] FS_TORQUE_GT = 6'h0f;
  localparam logic [5:0] FS_SPEED_GT = 6'h10;
  localparam logic [5:0] FS_POS_LIM = 6'h11;
  localparam logic [5:0] FS_SPEED_LIM = 6'h12;
  localparam logic [5:0] FS_TORQUE_LIM = 6'h13;
  localparam logic [5:0] FS_CONTACTOR = 6'h15;
  localparam logic [5:0] FS_PLC = 6'h16;
  localparam logic [5:0] FS_WARN_ANY = 6'h17;
  localparam logic [5:0] FS_WARN_FIRST = 6'h18;
  localparam logic [5:0] FS_WARN_LAST = 6'h21;
  localparam logic [5:0] FS_TABLE_ACT = 6'h22;
  localparam logic [5:0] FS_TAB_FIRST = 6'h23;
  localparam logic [5:0] FS_TAB_LAST = 6'h26;
  localparam logic [5:0] FS_BUS_FAST = 6'h27;
  localparam logic [5:0] FS_BUS_NC = 6'h28;
  localparam logic [5:0] FS_STO = 6'h37;
  localparam logic [5:0] FS_CHOPPER = 6'h38;
  localparam logic [5:0] FS_SYNC = 6'h39;
  localparam int unsigned NUM_WARN = 10;
  localparam logic [31:0] ADDR_OUT_SEL = 32'h0000_0000;
  localparam logic [31:0] ADDR_RELAY_SEL = 32'h0000_0004;
  localparam logic [31:0] ADDR_DELAY = 32'h0000_0008;
  localparam logic [31:0] ADDR_TORQUE_TH = 32'h0000_000c;
  localparam logic [31:0] ADDR_SPEED_TH = 32'h0000_0010;
  localparam logic [31:0] ADDR_WARN_LVL = 32'h0000_0014;
  localparam logic [31:0] ADDR_BUS_OUT = 32'h0000_0018;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_001c;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0020;
  localparam int unsigned MS_CYCLES = 100000;
  localparam logic [15:0] DELAY_RESET_MS = 16'h0064;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_SHUTDOWN_CLR = 1;
  typedef enum logic [2:0] {
    CT_OPEN = 3'b000,
    CT_CLOSING = 3'b001,
    CT_RUN = 3'b010,
    CT_STAGE_OFF = 3'b011,
    CT_OPENING = 3'b100
  } contactor_state_t;
  typedef struct packed {
    logic [15:0] torque;
    logic [15:0] speed;
    logic [15:0] dc_voltage;
    logic [15:0] stage_i2t;
    logic [15:0] motor_temp;
    logic [15:0] heatsink_temp;
    logic [15:0] internal_temp;
    logic [15:0] current;
    logic [15:0] motor_i2t;
  } drive_meas_t;
  typedef struct packed {
    logic halt;
    logic ref_at_limit;
    logic position_ref_limited;
    logic speed_ref_limited;
    logic torque_limited;
    logic plc_out;
    logic table_auto;
    logic table_on;
    logic [3:0] table_index;
    logic safe_torque_off_active;
    logic chopper_ok;
    logic sync_motion_engaged;
    logic nc_cycle;
  } drive_status_t;
endpackage

// ---- tb/contactor_model.sv ----
// partner model: machine start input and the motor power contactor
`timescale 1ns/100ps
`default_nettype none
module contactor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_cmd,
  input wire logic contactor_drive,
  input wire logic power_stage_enable,
  input wire logic reference_apply,
  output logic start_enable,
  output logic order_fault
);
  logic closed_ff;
  logic stage_ff;
  // contacts pull in one cycle after the coil is driven: mechanical lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed_ff <= 1'b0;
      stage_ff <= 1'b0;
      start_enable <= 1'b0;
      order_fault <= 1'b0;
    end else begin
      closed_ff <= contactor_drive;
      stage_ff <= power_stage_enable;
      start_enable <= run_cmd;
      if ((power_stage_enable || reference_apply) && !closed_ff) begin
        order_fault <= 1'b1;
      end
      // opening under current burns the contacts, so it is flagged too
      if (!contactor_drive && stage_ff) begin
        order_fault <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the drive output function selector
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, start_enable, relay_out, err;
  logic contactor_drive, power_stage_enable, reference_apply, run_cmd, order_fault;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] standard_output_n;
  drive_output_pkg::drive_meas_t meas, m0, m;
  drive_output_pkg::drive_status_t status, s0;
  int n_errors, check_count, cycles, n, hits;
  logic [5:0] codes [16] = '{6'h0d, 6'h0e, 6'h11, 6'h12, 6'h13, 6'h22, 6'h23, 6'h24, 6'h25,
                             6'h26, 6'h37, 6'h16, 6'h39, 6'h14, 6'h29, 6'h36};
  int slot [10] = '{6, 6, 5, 4, 3, 2, 1, 7, 0, 8};

  drive_output_function_select drive_output_function_select_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .status(status), .start_enable(start_enable),
    .standard_output_n(standard_output_n), .relay_out(relay_out),
    .contactor_drive(contactor_drive), .power_stage_enable(power_stage_enable),
    .reference_apply(reference_apply));
  contactor_model contactor_model_inst (.pclk(pclk), .presetn(presetn), .run_cmd(run_cmd),
    .contactor_drive(contactor_drive), .power_stage_enable(power_stage_enable),
    .reference_apply(reference_apply), .start_enable(start_enable), .order_fault(order_fault));

  always #5 pclk = ~pclk;

  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hang ends the run through the same verdict
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic step(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high; one idle cycle after each transfer
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic src(input logic [5:0] c, input logic on);
    drive_output_pkg::drive_status_t s;
    s = s0;
    if (on) begin
      case (c)
        6'h0d: s.halt = 1'b1;
        6'h0e: s.ref_at_limit = 1'b1;
        6'h11: s.position_ref_limited = 1'b1;
        6'h12: s.speed_ref_limited = 1'b1;
        6'h13: s.torque_limited = 1'b1;
        6'h22: begin
          s.table_auto = 1'b1;
          s.table_on = 1'b1;
        end
        6'h16: s.plc_out = 1'b1;
        6'h39: s.sync_motion_engaged = 1'b1;
        6'h23, 6'h24, 6'h25, 6'h26: s.table_index = 4'h1 << (c - 6'h23);
        6'h37: s.safe_torque_off_active = 1'b1;
        default: s = '1;
      endcase
    end
    status <= s;
  endtask

  task automatic out_chk(input logic [5:0] c, input logic on);
    wr(drive_output_pkg::ADDR_OUT_SEL, {14'h0, c, c, c});
    src(c, 1'b1);
    step(2);
    chk(32'(standard_output_n), 32'(on ? 3'b000 : 3'b111));
    src(c, 1'b0);
    step(2);
    chk(32'(standard_output_n), 32'(3'b111));
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, run_cmd} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    m0 = '0;
    m0.dc_voltage = 16'h8000;
    s0 = '0;
    s0.chopper_ok = 1'b1;
    meas = m0;
    status = s0;
    step(6);
    presetn <= 1'b1;
    step(1);
    chk(32'({standard_output_n, relay_out}), 32'(4'he));
    apb(1'b0, drive_output_pkg::ADDR_DELAY, 32'h0);
    chk(rd, 32'h64);
    apb(1'b0, 32'h0000_0040, 32'h0);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 16; i++) begin
      out_chk(codes[i], i < 13);
    end
    wr(drive_output_pkg::ADDR_TORQUE_TH, 32'h64);
    wr(drive_output_pkg::ADDR_SPEED_TH, 32'h64);
    wr(drive_output_pkg::ADDR_RELAY_SEL, 32'h0f);
    wr(drive_output_pkg::ADDR_OUT_SEL, {14'h0, 6'h00, 6'h10, 6'h0f});
    apb(1'b0, drive_output_pkg::ADDR_OUT_SEL, 32'h0);
    chk(rd, {14'h0, 6'h00, 6'h10, 6'h0f});
    m = m0;
    m.torque = 16'h65;
    m.speed = 16'h64;
    meas <= m;
    step(2);
    chk(32'({standard_output_n, relay_out}), 32'(4'hd));
    m.torque = 16'h64;
    m.speed = 16'h65;
    meas <= m;
    step(2);
    chk(32'({standard_output_n, relay_out}), 32'(4'ha));
    // one level for all warnings; undervoltage compares against its inverse
    wr(drive_output_pkg::ADDR_WARN_LVL, 32'hff00);
    for (int k = 0; k < 10; k++) begin
      wr(drive_output_pkg::ADDR_OUT_SEL, {14'h0, 6'h00, 6'h17, 6'(24 + k)});
      m = m0;
      m[slot[k] * 16 +: 16] = (k == 0) ? 16'h00ff : 16'hff00;
      meas <= m;
      step(2);
      chk(32'(standard_output_n), 32'(3'b100));
      meas <= m0;
      step(2);
      chk(32'(standard_output_n), 32'(3'b111));
    end
    wr(drive_output_pkg::ADDR_BUS_OUT, 32'h1);
    wr(drive_output_pkg::ADDR_OUT_SEL, {14'h0, 6'h00, 6'h00, 6'h28});
    step(2);
    chk(32'(standard_output_n), 32'(3'b111));
    status.nc_cycle <= 1'b1;
    step(1);
    status.nc_cycle <= 1'b0;
    step(3);
    chk(32'(standard_output_n), 32'(3'b110));
    // no millisecond tick has come yet, so the fast copy still holds its reset value
    wr(drive_output_pkg::ADDR_OUT_SEL, {14'h0, 6'h00, 6'h00, 6'h27});
    step(2);
    chk(32'(standard_output_n), 32'(3'b111));
    wr(drive_output_pkg::ADDR_OUT_SEL, {14'h0, 6'h00, 6'h00, 6'h38});
    status.chopper_ok <= 1'b0;
    step(3);
    chk(32'(standard_output_n), 32'(3'b110));
    status.chopper_ok <= 1'b1;
    step(3);
    chk(32'(standard_output_n), 32'(3'b110));
    wr(drive_output_pkg::ADDR_CTRL, 32'h2);
    step(2);
    chk(32'(standard_output_n), 32'(3'b111));
    wr(drive_output_pkg::ADDR_CTRL, 32'h1);
    run_cmd <= 1'b1;
    n = 0;
    while (reference_apply !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    chk(32'({contactor_drive, power_stage_enable, reference_apply}), 32'(3'b111));
    run_cmd <= 1'b0;
    n = 0;
    while (contactor_drive !== 1'b0 && n < 50) begin
      step(1);
      n++;
    end
    chk(32'({contactor_drive, power_stage_enable, reference_apply, order_fault}), 32'h0);
    // 1 ms delay outlasts the 2000-cycle window, so the stage must stay off throughout; real contactors need bounce margin
    wr(drive_output_pkg::ADDR_DELAY, 32'h1);
    wr(drive_output_pkg::ADDR_RELAY_SEL, 32'h15);
    run_cmd <= 1'b1;
    step(4);
    chk(32'({contactor_drive, relay_out}), 32'(2'b11));
    hits = 0;
    repeat (2000) begin
      step(1);
      hits += (power_stage_enable !== 1'b0);
    end
    chk(32'(hits), 32'h0);
    chk(32'(order_fault), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
